// ==== rtl/xls_pkg.sv ====
package xls_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int LANES = 8;
   localparam int CMD_W = 7;
   localparam int TP_W = 4;

   localparam logic [ADDR_W-1:0] OFS_EXTRA_A = 12'h20a;
   localparam logic [ADDR_W-1:0] OFS_EXTRA_B = 12'h20b;
   localparam logic [ADDR_W-1:0] OFS_SH_CONTENT = 12'h20f;

   localparam logic [DATA_W-1:0] RST_EXTRA = 8'h00;
   localparam logic [DATA_W-1:0] RST_SH_CONTENT = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

   // Field positions
   localparam int SER_BIT = 0;
   localparam int SH_LSB = 0;
   localparam int SH_MSB = 1;

   typedef enum logic [1:0]
   {
      XLS_SH_CRC12 = 2'h0,
      XLS_SH_RSVD1 = 2'h1,
      XLS_SH_FEC = 2'h2,
      XLS_SH_RSVD3 = 2'h3
   } xls_sh_t;

   localparam logic [TP_W-1:0] TP_NONE = 4'h0;
   localparam logic [TP_W-1:0] TP_RAMP = 4'h4;
   localparam logic [TP_W-1:0] TP_ALT = 4'h5;

   localparam logic [CMD_W-1:0] CMD_IDLE = 7'h00;
   localparam int SH_DATA_BITS = 32;
endpackage

// ==== rtl/xls_extra_lane_cfg.sv ====
`timescale 1ns/1ps

// Behaviour
// [RULE1] Link A bits 7:1 force lanes A1..A7 on beyond link mode needs.
// [RULE2] Link B bits 7:1 force lanes B1..B7 on beyond link mode needs.
// [RULE3] Serializer bit 0 low: forced lanes get link-layer clocks only.
// [RULE4] Serializer bit 0 high: forced lanes get clocks and running serializers.
// [RULE5] Software changes these registers only while global link enable is low.
// [RULE6] Extra lanes follow current link mode and test pattern rate and mode.
// [RULE7] Forced-only lanes send octet ramp when test pattern is 0 or 5.
// [RULE8] Forced lanes never override channel power-down; link must stay enabled.
// [RULE9] Serializer n clocked only when lanes 0 to n-1 are all enabled.
// [RULE10] Bits 1:0 pick sync-header content, effective only in 64b/66b modes.
// [RULE11] Code 0 sends CRC-12, code 2 sends FEC; 1 and 3 reserved.
// [RULE12] All command fields transmitted as zero, giving idle headers.
// [RULE13] All three registers reset to 0x00: no extra lanes, CRC-12.
// [RULE14] Both channels powered down shuts whole link subsystem regardless of forcing.
// [RULE15] Reserved sync-header bits store and read back but steer nothing.
module xls_extra_lane_cfg
   import xls_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rdata_valid,
   input wire logic link_global_enable,
   input wire logic mode_is_64b66b,
   input wire logic [TP_W-1:0] test_pattern_select,
   input wire logic [1:0] channel_power_down,
   input wire logic [LANES-1:0] mode_lanes_a,
   input wire logic [LANES-1:0] mode_lanes_b,
   output logic [LANES-1:0] lane_clk_en_a,
   output logic [LANES-1:0] lane_clk_en_b,
   output logic [LANES-1:0] ser_en_a,
   output logic [LANES-1:0] ser_en_b,
   output logic [LANES-1:0] ramp_force_a,
   output logic [LANES-1:0] ramp_force_b,
   output logic crc12_enable,
   output logic fec_enable,
   output logic [CMD_W-1:0] sh_command,
   output logic subsystem_pd
);

   logic [DATA_W-1:0] extra_lane_reg_link_a_reg;
   logic [DATA_W-1:0] extra_lane_reg_link_a_next;
   logic [DATA_W-1:0] extra_lane_reg_link_b_reg;
   logic [DATA_W-1:0] extra_lane_reg_link_b_next;
   logic [DATA_W-1:0] sync_header_content_reg;
   logic [DATA_W-1:0] sync_header_content_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;

   logic [LANES-1:0] lane_clk_a_reg, lane_clk_a_next;
   logic [LANES-1:0] lane_clk_b_reg, lane_clk_b_next;
   logic [LANES-1:0] ser_a_reg, ser_a_next;
   logic [LANES-1:0] ser_b_reg, ser_b_next;
   logic [LANES-1:0] ramp_a_reg, ramp_a_next;
   logic [LANES-1:0] ramp_b_reg, ramp_b_next;
   logic crc_reg, crc_next;
   logic fec_reg, fec_next;
   logic [CMD_W-1:0] cmd_reg;
   logic [CMD_W-1:0] cmd_next;
   logic pd_reg, pd_next;

   logic [LANES-1:0] forced_a, forced_b;
   logic [LANES-1:0] any_a, any_b;
   logic [LANES-1:0] chain_a, chain_b;
   logic forced_serializer_on_a, forced_serializer_on_b;
   logic link_ok_a, link_ok_b;
   logic ramp_pattern;
   xls_sh_t sh_code;

   // Register file
   always_comb
   begin
      extra_lane_reg_link_a_next = extra_lane_reg_link_a_reg;
      extra_lane_reg_link_b_next = extra_lane_reg_link_b_reg;
      sync_header_content_next = sync_header_content_reg;
      rdata_next = rdata_reg;
      rvalid_next = reg_rd_en;
      // [RULE5] Writes trusted to come while link disabled
      if (reg_wr_en)
      begin
         case (reg_addr)
            OFS_EXTRA_A: extra_lane_reg_link_a_next = reg_wdata;
            OFS_EXTRA_B: extra_lane_reg_link_b_next = reg_wdata;
            // [RULE15] Whole byte kept for readback
            OFS_SH_CONTENT: sync_header_content_next = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd_en)
      begin
         case (reg_addr)
            OFS_EXTRA_A: rdata_next = extra_lane_reg_link_a_reg;
            OFS_EXTRA_B: rdata_next = extra_lane_reg_link_b_reg;
            OFS_SH_CONTENT: rdata_next = sync_header_content_reg;
            default: rdata_next = RDATA_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         // [RULE13] All registers clear
         extra_lane_reg_link_a_reg <= RST_EXTRA;
         extra_lane_reg_link_b_reg <= RST_EXTRA;
         sync_header_content_reg <= RST_SH_CONTENT;
         rdata_reg <= RDATA_UNMAPPED;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         extra_lane_reg_link_a_reg <= extra_lane_reg_link_a_next;
         extra_lane_reg_link_b_reg <= extra_lane_reg_link_b_next;
         sync_header_content_reg <= sync_header_content_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // [RULE1] Lane 0 is never forced
   assign forced_a = {extra_lane_reg_link_a_reg[LANES-1:1], 1'b0};
   // [RULE2] Same layout for link B
   assign forced_b = {extra_lane_reg_link_b_reg[LANES-1:1], 1'b0};
   assign forced_serializer_on_a = extra_lane_reg_link_a_reg[SER_BIT];
   assign forced_serializer_on_b = extra_lane_reg_link_b_reg[SER_BIT];
   assign any_a = forced_a | mode_lanes_a;
   assign any_b = forced_b | mode_lanes_b;
   // [RULE8] Power-down of a channel wins over forcing
   // Both-down test taken from the pins, not pd_next, to keep the lane logic loop-free
   assign link_ok_a = link_global_enable && !channel_power_down[0] && !(&channel_power_down);
   assign link_ok_b = link_global_enable && !channel_power_down[1] && !(&channel_power_down);
   // [RULE7] Ramp substitutes for patterns 0 and 5
   assign ramp_pattern = (test_pattern_select == TP_NONE) || (test_pattern_select == TP_ALT);
   assign sh_code = xls_sh_t'(sync_header_content_reg[SH_MSB:SH_LSB]);

   // [RULE9] Serializer clock chain needs all lower lanes
   assign chain_a[0] = 1'b1;
   assign chain_b[0] = 1'b1;
   genvar gi;
   generate
      for (gi = 1; gi < LANES; gi++)
      begin : g_chain
         assign chain_a[gi] = chain_a[gi-1] & any_a[gi-1];
         assign chain_b[gi] = chain_b[gi-1] & any_b[gi-1];
      end
   endgenerate

   // Lane control; rate and mode otherwise follow the link mode
   always_comb
   begin
      // [RULE14] Both channels down kills the subsystem
      pd_next = &channel_power_down;
      // [RULE3] Forced lanes get link-layer clocks whenever link_ok_a or link_ok_b is high for their link
      lane_clk_a_next = link_ok_a ? any_a : '0;
      lane_clk_b_next = link_ok_b ? any_b : '0;
      // [RULE4] Forced serializers only with serializer bit set
      ser_a_next = (mode_lanes_a | (forced_serializer_on_a ? forced_a : '0)) & chain_a;
      ser_b_next = (mode_lanes_b | (forced_serializer_on_b ? forced_b : '0)) & chain_b;
      if (!link_ok_a)
      begin
         ser_a_next = '0;
      end
      if (!link_ok_b)
      begin
         ser_b_next = '0;
      end
      // [RULE6] Only forced-only lanes depart from selected pattern
      ramp_a_next = (ramp_pattern && link_ok_a) ? (forced_a & ~mode_lanes_a) : '0;
      ramp_b_next = (ramp_pattern && link_ok_b) ? (forced_b & ~mode_lanes_b) : '0;
      // [RULE10] Content only matters in 64b/66b modes
      // [RULE11] Reserved codes fall back to CRC-12 to keep a valid header
      crc_next = 1'b0;
      fec_next = 1'b0;
      if (mode_is_64b66b && !pd_next)
      begin
         case (sh_code)
            XLS_SH_FEC: fec_next = 1'b1;
            XLS_SH_CRC12: crc_next = 1'b1;
            default: crc_next = 1'b1;
         endcase
      end
      // [RULE12] Command channel unsupported
      cmd_next = CMD_IDLE;
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         lane_clk_a_reg <= '0;
         lane_clk_b_reg <= '0;
         ser_a_reg <= '0;
         ser_b_reg <= '0;
         ramp_a_reg <= '0;
         ramp_b_reg <= '0;
         crc_reg <= 1'b0;
         fec_reg <= 1'b0;
         cmd_reg <= CMD_IDLE;
         pd_reg <= 1'b0;
      end
      else
      begin
         lane_clk_a_reg <= lane_clk_a_next;
         lane_clk_b_reg <= lane_clk_b_next;
         ser_a_reg <= ser_a_next;
         ser_b_reg <= ser_b_next;
         ramp_a_reg <= ramp_a_next;
         ramp_b_reg <= ramp_b_next;
         crc_reg <= crc_next;
         fec_reg <= fec_next;
         cmd_reg <= cmd_next;
         pd_reg <= pd_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign reg_rdata_valid = rvalid_reg;
   assign lane_clk_en_a = lane_clk_a_reg;
   assign lane_clk_en_b = lane_clk_b_reg;
   assign ser_en_a = ser_a_reg;
   assign ser_en_b = ser_b_reg;
   assign ramp_force_a = ramp_a_reg;
   assign ramp_force_b = ramp_b_reg;
   assign crc12_enable = crc_reg;
   assign fec_enable = fec_reg;
   assign sh_command = cmd_reg;
   assign subsystem_pd = pd_reg;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   a_lane_a_force: assert property ( // [RULE1]
      (link_global_enable && channel_power_down == 2'b00)
      |=> (lane_clk_en_a[LANES-1:1] & $past(extra_lane_reg_link_a_reg[LANES-1:1]))
          == $past(extra_lane_reg_link_a_reg[LANES-1:1]))
      else $error("forced lane A lacks clock");
   a_lane_b_force: assert property ( // [RULE2]
      (link_global_enable && channel_power_down == 2'b00)
      |=> (lane_clk_en_b[LANES-1:1] & $past(extra_lane_reg_link_b_reg[LANES-1:1]))
          == $past(extra_lane_reg_link_b_reg[LANES-1:1]))
      else $error("forced lane B lacks clock");
   a_clock_only: assert property ( // [RULE3]
      (!extra_lane_reg_link_a_reg[SER_BIT])
      |=> (ser_en_a & ~$past(mode_lanes_a)) == '0)
      else $error("serializer on without serializer bit");
   a_ser_follows: assert property ( // [RULE4]
      (extra_lane_reg_link_b_reg[SER_BIT] && link_global_enable && channel_power_down == 2'b00
       && mode_lanes_b == 8'h01 && extra_lane_reg_link_b_reg[1])
      |=> ser_en_b[1])
      else $error("forced serializer B1 not running");
   a_ramp_pattern: assert property ( // [RULE7]
      (ramp_force_a != '0) |-> $past(test_pattern_select == TP_NONE || test_pattern_select == TP_ALT))
      else $error("ramp forced under wrong test pattern");
   a_pd_wins: assert property ( // [RULE8]
      (!link_global_enable || channel_power_down[0])
      |=> lane_clk_en_a == '0 && ser_en_a == '0)
      else $error("link A lanes live while powered down");
   a_ser_chain: assert property ( // [RULE9]
      ser_en_a[3] |-> &$past(mode_lanes_a[2:0] | extra_lane_reg_link_a_reg[2:0] & 3'h6))
      else $error("serializer 3 clocked with gap below");
   a_sh_gate: assert property ( // [RULE10]
      !mode_is_64b66b |=> !crc12_enable && !fec_enable)
      else $error("sync header content outside 64b66b");
   a_sh_codes: assert property ( // [RULE11]
      fec_enable |-> $past(sync_header_content_reg[SH_MSB:SH_LSB]) == XLS_SH_FEC && !crc12_enable)
      else $error("FEC without code 2");
   a_cmd_idle: assert property ( // [RULE12]
      sh_command == CMD_IDLE)
      else $error("command field not idle");
   a_subsys_pd: assert property ( // [RULE14]
      (channel_power_down == 2'b11) |=> subsystem_pd && ser_en_a == '0 && ser_en_b == '0)
      else $error("subsystem alive with both channels down");
   a_rsvd_inert: assert property ( // [RULE15]
      (mode_is_64b66b && channel_power_down != 2'b11
       && sync_header_content_reg[SH_MSB:SH_LSB] == XLS_SH_CRC12) |=> crc12_enable)
      else $error("reserved bits disturbed CRC select");
   a_ramp_forced_only: assert property ( // [RULE6]
      (ramp_force_b & ~$past(extra_lane_reg_link_b_reg & ~mode_lanes_b)) == '0)
      else $error("ramp on lane that is not forced alone");
   a_reset_clear: assert property ( // [RULE13]
      disable iff (1'b0)
      srst |=> extra_lane_reg_link_a_reg == RST_EXTRA && extra_lane_reg_link_b_reg == RST_EXTRA
          && sync_header_content_reg == RST_SH_CONTENT)
      else $error("registers not cleared by reset");

   c_forced_ser: cover property (ser_en_a[7] && !$past(mode_lanes_a[7]));
   c_ramp_b: cover property (ramp_force_b != '0);
   c_fec: cover property (fec_enable);
   c_readback: cover property (reg_rdata_valid && reg_rdata != '0);
   c_chain_gap: cover property (lane_clk_en_a[3] && !ser_en_a[3]);
endmodule

// ==== testbench/xls_lane_rx.sv ====
`timescale 1ns/1ps

// Receiver side: a lane carries data only with both clock and serializer
module xls_lane_rx
   import xls_pkg::*;
(
   input wire logic clock,
   input wire logic [LANES-1:0] lane_clk_en,
   input wire logic [LANES-1:0] ser_en,
   input wire logic [CMD_W-1:0] sh_command,
   output logic [LANES-1:0] lanes_live,
   output logic hdr_idle
);
   always_ff @(posedge clock)
   begin
      lanes_live <= lane_clk_en & ser_en;
      hdr_idle <= (sh_command == CMD_IDLE);
   end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps

module testbench;
   import xls_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [ADDR_W-1:0] addr = 12'h000;
   logic [DATA_W-1:0] wdata = 8'h00;
   logic [DATA_W-1:0] rdata, v;
   logic rvalid, glb_en = 1'b0, m64 = 1'b0;
   logic [TP_W-1:0] tp = 4'h0;
   logic [1:0] pd = 2'h0;
   logic [LANES-1:0] mla = 8'h01;
   logic [LANES-1:0] mlb = 8'h01;
   logic [LANES-1:0] clk_a, clk_b, ser_a, ser_b, rmp_a, rmp_b, live_a;
   logic crc, fec, spd, hdr_idle;
   logic [CMD_W-1:0] cmd;
   int bad_count = 0;
   int compares = 0;

   xls_extra_lane_cfg dut_u (.clock(clock), .srst(srst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rdata_valid(rvalid),
      .link_global_enable(glb_en), .mode_is_64b66b(m64), .test_pattern_select(tp),
      .channel_power_down(pd), .mode_lanes_a(mla), .mode_lanes_b(mlb), .lane_clk_en_a(clk_a),
      .lane_clk_en_b(clk_b), .ser_en_a(ser_a), .ser_en_b(ser_b), .ramp_force_a(rmp_a),
      .ramp_force_b(rmp_b), .crc12_enable(crc), .fec_enable(fec), .sh_command(cmd),
      .subsystem_pd(spd));
   xls_lane_rx rx_u (.clock(clock), .lane_clk_en(clk_a), .ser_en(ser_a), .sh_command(cmd),
      .lanes_live(live_a), .hdr_idle(hdr_idle));

   initial
   begin
      forever #20 clock = ~clock;
   end

   task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // link held off around every write
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      glb_en <= 1'b0;
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr_en <= 1'b0;
      glb_en <= 1'b1;
   endtask

   task rd(input logic [11:0] a);
      @(posedge clock);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      chk("rvalid", {7'h00, rvalid}, 8'h01);
      v = rdata;
   endtask

   // Registered outputs lag the register by one more edge
   task settle;
      repeat (3) @(posedge clock);
      #1;
   endtask

   task t_reset;
      rd(OFS_EXTRA_A);
      chk("extra_a", v, 8'h00);
      rd(OFS_EXTRA_B);
      chk("extra_b", v, 8'h00);
      rd(OFS_SH_CONTENT);
      chk("sh", v, 8'h00);
      chk("clk_a", clk_a, 8'h00);
   endtask

   task t_link_a;
      wr(OFS_EXTRA_A, 8'h06);
      settle;
      chk("clk_a", clk_a, 8'h07);
      chk("ser_a", ser_a, 8'h01);
      chk("rmp_a", rmp_a, 8'h06);
      wr(OFS_EXTRA_A, 8'h0b);
      settle;
      chk("clk_a", clk_a, 8'h0b);
      chk("ser_a", ser_a, 8'h03);
      chk("live_a", live_a, 8'h03);
      wr(OFS_EXTRA_A, 8'h07);
      @(posedge clock) tp <= TP_ALT;
      settle;
      chk("ser_a", ser_a, 8'h07);
      chk("rmp_a", rmp_a, 8'h06);
      @(posedge clock) mla <= 8'h03;
      settle;
      chk("rmp_a", rmp_a, 8'h04);
      @(posedge clock) tp <= TP_RAMP;
      settle;
      chk("rmp_a", rmp_a, 8'h00);
      @(posedge clock) tp <= TP_NONE;
      mla <= 8'h01;
   endtask

   task t_link_b;
      wr(OFS_EXTRA_B, 8'h05);
      settle;
      chk("clk_b", clk_b, 8'h05);
      chk("ser_b", ser_b, 8'h01);
      chk("rmp_b", rmp_b, 8'h04);
      rd(OFS_EXTRA_B);
      chk("extra_b", v, 8'h05);
   endtask

   task t_pd;
      @(posedge clock) pd <= 2'h1;
      settle;
      chk("clk_a", clk_a, 8'h00);
      chk("clk_b", clk_b, 8'h05);
      chk("spd", {7'h00, spd}, 8'h00);
      @(posedge clock) pd <= 2'h3;
      settle;
      chk("spd", {7'h00, spd}, 8'h01);
      chk("ser_b", ser_b, 8'h00);
      @(posedge clock) pd <= 2'h0;
   endtask

   task t_sh;
      logic [7:0] d;
      @(posedge clock) m64 <= 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         d = {6'h2a, 2'(c)};
         wr(OFS_SH_CONTENT, d);
         settle;
         chk("fec", {7'h00, fec}, {7'h00, c == 2});
         chk("crc", {7'h00, crc}, {7'h00, c != 2});
         chk("idle", {7'h00, hdr_idle}, 8'h01);
         rd(OFS_SH_CONTENT);
         chk("sh", v, d);
      end
      @(posedge clock) m64 <= 1'b0;
      settle;
      chk("crc", {7'h00, crc}, 8'h00);
      chk("fec", {7'h00, fec}, 8'h00);
   endtask

   task t_unmapped;
      wr(12'h20c, 8'hff);
      rd(12'h20c);
      chk("unmapped", v, RDATA_UNMAPPED);
      rd(OFS_EXTRA_A);
      chk("extra_a", v, 8'h07);
   endtask

   task print_verdict;
      $display("Checks %0d, errors %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      t_reset;
      t_link_a;
      t_link_b;
      t_pd;
      t_sh;
      t_unmapped;
      print_verdict;
   end

   // Whole run is about a hundred cycles
   initial
   begin
      #400000;
      bad_count++;
      print_verdict;
   end
endmodule
